// ===== hdl/cpp_pkg.sv
// Purpose: Shared constants for the control port pin function block
// Assumes: 40 MHz system clock, 8-bit register space of 64 locations
// Notes: Mode and select encodings follow the pin definitions
package cpp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 6;
  localparam int DEPTH = 64;
  // Interface mode select
  localparam logic [1:0] MODE_HW = 2'h0;
  localparam logic [1:0] MODE_SERIAL = 2'h1;
  localparam logic [1:0] MODE_STROBE_DIR = 2'h2;
  localparam logic [1:0] MODE_SEP_STROBE = 2'h3;
  // Channel 1 transmit pattern codes
  localparam logic [1:0] PATT_NORMAL = 2'h0;
  localparam logic [1:0] PATT_ONES = 2'h1;
  localparam logic [1:0] PATT_PRBS = 2'h2;
  localparam logic [1:0] PATT_PWRDN = 2'h3;
  // Channel 2 loopback codes
  localparam logic [1:0] LB_NONE = 2'h0;
  localparam logic [1:0] LB_ANALOG = 2'h1;
  localparam logic [1:0] LB_DIGITAL = 2'h2;
  localparam logic [1:0] LB_REMOTE = 2'h3;
  // Software control register holding channel 2 loopback incl. inband
  localparam logic [5:0] LOOP_REG_ADDR = 6'h02;
  localparam int LOOP_INBAND_BIT = 2;
  // Serial frame: R/W bit, 6 address bits, 1 spare, 8 data bits
  localparam int SER_FRAME_BITS = 16;
  localparam logic [4:0] SER_CMD_BITS = 5'h08;
  localparam logic [7:0] RESET_DATA = 8'h00;
endpackage

// ===== hdl/cpp_regmem.sv
// Purpose: Small register memory for the control port
// Assumes: One write and one read port on one clock
// Notes: Read data come out of a register one cycle after the address
`timescale 1ns/1ps
module cpp_regmem (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Write side
  input wire logic wr_en,
  input wire logic [cpp_pkg::ADDR_W-1:0] wr_addr,
  input wire logic [cpp_pkg::DATA_W-1:0] wr_data,
  // Read side
  input wire logic [cpp_pkg::ADDR_W-1:0] rd_addr,
  output logic [cpp_pkg::DATA_W-1:0] rd_data
);
  logic [cpp_pkg::DATA_W-1:0] mem_r [cpp_pkg::DEPTH];

  // Storage array, cleared on reset so reads are defined
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < cpp_pkg::DEPTH; i++) begin
        mem_r[i] <= cpp_pkg::RESET_DATA;
      end
    end else if (clk_en && wr_en) begin
      mem_r[wr_addr] <= wr_data;
    end
  end

  // Registered read port
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_data <= cpp_pkg::RESET_DATA;
    end else if (clk_en) begin
      rd_data <= (wr_en && wr_addr == rd_addr) ? wr_data : mem_r[rd_addr];
    end
  end
endmodule

// ===== hdl/cpp_port.sv
// Purpose: Control port of a dual channel line interface device
// Assumes: All port pins are asynchronous to clk and are synchronised
// Notes: Shift clock edges are found by oversampling at 40 MHz
`timescale 1ns/1ps
// Function
// - Serial input bit captured on each shift clock rising edge.
// - Serial output launched on rising edge if edge select low, else fall.
// - Data strobe latches bus on writes, device drives bus on reads.
// - Separate style: bus driven while read strobe held low.
// - Separate style: write strobe rising edge commits write, bus captured.
// - Hardware mode pattern select: normal, ones, PRBS, power down.
// - Hardware mode loopback select: none, analog, digital, remote.
// - Inband loopback only under software control, never hardware mode.
// - Chip select low enables access; port ignored while high.
module cpp_port (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  // Interface mode strap
  input wire logic [1:0] if_mode,
  // Chip select
  input wire logic chip_sel_n,
  // Serial port pins
  input wire logic shift_clk,
  input wire logic output_edge_select,
  input wire logic serial_in,
  output logic serial_out,
  // Parallel port pins
  input wire logic [cpp_pkg::ADDR_W-1:0] addr,
  input wire logic parallel_data_strobe_n,
  input wire logic read_not_write,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [cpp_pkg::DATA_W-1:0] data_in,
  output logic [cpp_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  // Hardware mode select pins
  input wire logic [1:0] ch1_pattern_select,
  input wire logic [1:0] ch2_loopback_select,
  // Resulting channel controls
  output logic [1:0] ch1_tx_pattern_r,
  output logic [1:0] ch2_loopback_r,
  output logic ch2_inband_loop_r
);
  typedef enum logic [1:0] {SER_IDLE, SER_CMD, SER_DATA} cpp_ser_e;

  // Synchroniser stages
  logic [13:0] s1_r;
  logic [13:0] s2_r;
  logic [cpp_pkg::ADDR_W-1:0] addr1_r, addr_s;
  logic [cpp_pkg::DATA_W-1:0] din1_r, din_s;
  logic [3:0] hw1_r, hw_s;
  logic sclk_d_r;
  logic strobe_d_r;
  logic wrs_d_r;
  cpp_ser_e ser_st_r;
  logic [4:0] bit_cnt_r;
  logic ser_read_r;
  logic [cpp_pkg::ADDR_W-1:0] ser_addr_r;
  logic [cpp_pkg::DATA_W-1:0] ser_shift_r;
  logic [cpp_pkg::DATA_W-1:0] ser_out_sh_r;
  logic ser_load_r;
  logic wr_en;
  logic [cpp_pkg::ADDR_W-1:0] wr_addr;
  logic [cpp_pkg::DATA_W-1:0] wr_data;
  logic [cpp_pkg::ADDR_W-1:0] rd_addr;
  logic [cpp_pkg::DATA_W-1:0] rd_data;
  logic [1:0] mode_r;

  function automatic logic is_mode(input logic [1:0] m,
                                   input logic [1:0] want);
    is_mode = (m == want);
  endfunction

  // Two-stage synchronisers for every pin
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      // Idle pin levels, so no false strobe or shift edge after reset
      s1_r <= 14'h0F80;
      s2_r <= 14'h0F80;
      addr1_r <= '0;
      addr_s <= '0;
      din1_r <= '0;
      din_s <= '0;
      hw1_r <= 4'h0;
      hw_s <= 4'h0;
    end else if (clk_en) begin
      s1_r <= {if_mode, chip_sel_n, parallel_data_strobe_n, read_strobe_n,
               write_strobe_n, read_not_write, 4'h0, shift_clk,
               output_edge_select, serial_in};
      s2_r <= s1_r;
      addr1_r <= addr;
      addr_s <= addr1_r;
      din1_r <= data_in;
      din_s <= din1_r;
      hw1_r <= {ch1_pattern_select, ch2_loopback_select};
      hw_s <= hw1_r;
    end
  end

  wire cs_s = ~s2_r[11];
  wire ds_n_s = s2_r[10];
  wire rd_n_s = s2_r[9];
  wire wr_n_s = s2_r[8];
  wire rnw_s = s2_r[7];
  wire sclk_s = s2_r[2];
  wire edge_sel_s = s2_r[1];
  wire sdi_s = s2_r[0];

  // Mode register follows strap once synchronised
  always_ff @(posedge clk or posedge reset) begin
    if (reset) mode_r <= cpp_pkg::MODE_HW;
    else if (clk_en) mode_r <= s2_r[13:12];
  end

  // Edge detect history
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_d_r <= 1'b0;
      strobe_d_r <= 1'b1;
      wrs_d_r <= 1'b1;
    end else if (clk_en) begin
      sclk_d_r <= sclk_s;
      strobe_d_r <= ds_n_s;
      wrs_d_r <= wr_n_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_r;
  wire sclk_fall = ~sclk_s & sclk_d_r;
  wire ser_on = is_mode(mode_r, cpp_pkg::MODE_SERIAL) & cs_s;
  wire sd_on = is_mode(mode_r, cpp_pkg::MODE_STROBE_DIR) & cs_s;
  wire sp_on = is_mode(mode_r, cpp_pkg::MODE_SEP_STROBE) & cs_s;
  // Write commits on the strobe's rising edge, data then held stable
  wire sd_wr = sd_on & ~rnw_s & ds_n_s & ~strobe_d_r;
  wire sp_wr = sp_on & wr_n_s & ~wrs_d_r;
  wire launch_edge = edge_sel_s ? sclk_fall : sclk_rise;

  // Serial receive state machine, shifts on shift clock rise
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ser_st_r <= SER_IDLE;
      bit_cnt_r <= 5'h00;
      ser_read_r <= 1'b0;
      ser_addr_r <= '0;
      ser_shift_r <= '0;
    end else if (clk_en) begin
      if (!ser_on) begin
        ser_st_r <= SER_IDLE;
        bit_cnt_r <= 5'h00;
      end else if (sclk_rise) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
        case (ser_st_r)
          SER_IDLE: begin
            ser_read_r <= sdi_s;
            ser_st_r <= SER_CMD;
          end
          SER_CMD: begin
            if (bit_cnt_r <= 5'h06) ser_addr_r <= {sdi_s, ser_addr_r[5:1]};
            if (bit_cnt_r == cpp_pkg::SER_CMD_BITS - 5'h01) begin
              ser_st_r <= SER_DATA;
            end
          end
          SER_DATA: begin
            ser_shift_r <= {sdi_s, ser_shift_r[7:1]};
          end
          default: ser_st_r <= SER_IDLE;
        endcase
      end
    end
  end

  wire ser_wr = ser_on & sclk_rise & (ser_st_r == SER_DATA) & ~ser_read_r &
                (bit_cnt_r == 5'(cpp_pkg::SER_FRAME_BITS - 1));

  // Register write source selection
  always_comb begin
    wr_en = 1'b0;
    wr_addr = addr_s;
    wr_data = din_s;
    if (ser_wr) begin
      wr_en = 1'b1;
      wr_addr = ser_addr_r;
      wr_data = {sdi_s, ser_shift_r[7:1]};
    end else if (sd_wr || sp_wr) begin
      wr_en = 1'b1;
    end
  end

  assign rd_addr = ser_on ? ser_addr_r : addr_s;

  cpp_regmem cpp_regmem_i (
    .clk(clk),
    .reset(reset),
    .clk_en(clk_en),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // Serial output shifter; loads at start of data phase, LSB first
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ser_out_sh_r <= '0;
      ser_load_r <= 1'b0;
      serial_out <= 1'b0;
    end else if (clk_en) begin
      ser_load_r <= ser_on & (ser_st_r == SER_DATA);
      if (!ser_on) begin
        serial_out <= 1'b0;
      end else if (ser_st_r == SER_DATA && !ser_load_r) begin
        ser_out_sh_r <= rd_data;
      end else if (launch_edge && ser_read_r && ser_st_r == SER_DATA) begin
        serial_out <= ser_out_sh_r[0];
        ser_out_sh_r <= {1'b0, ser_out_sh_r[7:1]};
      end
    end
  end

  // Parallel read drive, held for the whole strobe low time
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      data_oe <= 1'b0;
      data_out <= '0;
    end else if (clk_en) begin
      data_oe <= (sd_on & rnw_s & ~ds_n_s) | (sp_on & ~rd_n_s);
      data_out <= rd_data;
    end
  end

  // Channel controls: pins in hardware mode, else loopback register sets ch2 and ch1 pattern holds
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ch1_tx_pattern_r <= cpp_pkg::PATT_NORMAL;
      ch2_loopback_r <= cpp_pkg::LB_NONE;
      ch2_inband_loop_r <= 1'b0;
    end else if (clk_en) begin
      if (is_mode(mode_r, cpp_pkg::MODE_HW)) begin
        ch1_tx_pattern_r <= hw_s[3:2];
        ch2_loopback_r <= hw_s[1:0];
        ch2_inband_loop_r <= 1'b0;
      end else if (wr_en && wr_addr == cpp_pkg::LOOP_REG_ADDR) begin
        ch2_loopback_r <= wr_data[1:0];
        ch2_inband_loop_r <= wr_data[cpp_pkg::LOOP_INBAND_BIT];
      end
    end
  end

  // Assertions
  property p_hw_no_inband;
    @(posedge clk) disable iff (reset)
    (clk_en && is_mode(mode_r, cpp_pkg::MODE_HW)) |=> !ch2_inband_loop_r;
  endproperty
  a_hw_no_inband: assert property (p_hw_no_inband)
    else $error("inband loop set in hardware mode");

  property p_hw_patt;
    @(posedge clk) disable iff (reset)
    (clk_en && is_mode(mode_r, cpp_pkg::MODE_HW)) |=>
      ch1_tx_pattern_r == $past(hw_s[3:2]);
  endproperty
  a_hw_patt: assert property (p_hw_patt)
    else $error("pattern not following pins");

  property p_hw_loop;
    @(posedge clk) disable iff (reset)
    (clk_en && is_mode(mode_r, cpp_pkg::MODE_HW)) |=>
      ch2_loopback_r == $past(hw_s[1:0]);
  endproperty
  a_hw_loop: assert property (p_hw_loop)
    else $error("loopback not following pins");

  property p_cs_quiet;
    @(posedge clk) disable iff (reset)
    (clk_en && !cs_s) |=> !data_oe;
  endproperty
  a_cs_quiet: assert property (p_cs_quiet)
    else $error("bus driven without chip select");

  property p_rd_drive;
    @(posedge clk) disable iff (reset)
    (clk_en && sp_on && !rd_n_s) |=> data_oe;
  endproperty
  a_rd_drive: assert property (p_rd_drive)
    else $error("no drive during read strobe");

  property p_ds_drive;
    @(posedge clk) disable iff (reset)
    (clk_en && sd_on && rnw_s && !ds_n_s) |=> data_oe;
  endproperty
  a_ds_drive: assert property (p_ds_drive)
    else $error("no drive during data strobe read");

  property p_wr_commit;
    @(posedge clk) disable iff (reset)
    (clk_en && sp_wr) |-> (wr_en && wr_data == din_s);
  endproperty
  a_wr_commit: assert property (p_wr_commit)
    else $error("write strobe did not commit");

  property p_launch_only;
    @(posedge clk) disable iff (reset)
    (clk_en && ser_on && $changed(serial_out) && $past(ser_on)) |->
      $past(launch_edge);
  endproperty
  a_launch_only: assert property (p_launch_only)
    else $error("serial out changed off launch edge");

  // Commit must sit on a seen shift clock rise, last bit taken then
  property p_ser_capture;
    @(posedge clk) disable iff (reset)
    (clk_en && $past(clk_en) && ser_wr) |->
      (wr_data[7] == sdi_s && sclk_s && !$past(sclk_s));
  endproperty
  a_ser_capture: assert property (p_ser_capture)
    else $error("serial bit not captured on rise");
endmodule

// ===== tb/cpp_host_model.sv
// Purpose: Host microcontroller model on the serial and parallel pins
// Assumes: 40 MHz clk, shift clock of 200 ns made from clk edges
// Notes: Bus pull-down and two-way resolution live in the bench
`timescale 1ns/1ps
module cpp_host_model (
  // Clock
  input wire logic clk,
  // Select and serial pins
  output logic chip_sel_n,
  output logic shift_clk,
  output logic output_edge_select,
  output logic serial_in,
  input wire logic serial_out,
  // Parallel pins
  output logic [cpp_pkg::ADDR_W-1:0] addr,
  output logic parallel_data_strobe_n,
  output logic read_not_write,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [7:0] host_data,
  output logic host_oe,
  input wire logic [7:0] bus
);
  // Idle pins at time zero, shift clock parked low
  initial begin
    chip_sel_n = 1'b1;
    shift_clk = 1'b0;
    output_edge_select = 1'b0;
    serial_in = 1'b0;
    addr = '0;
    parallel_data_strobe_n = 1'b1;
    read_not_write = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    host_data = 8'h00;
    host_oe = 1'b0;
  end

  // One parallel cycle; strobe held 8 clocks to cover the sync delay
  task par(input logic sep, input logic rd, input logic cs,
           input logic [5:0] a, input logic [7:0] d, output logic [7:0] q);
    q = 8'h00;
    @(posedge clk);
    chip_sel_n <= !cs;
    addr <= a;
    read_not_write <= rd;
    host_data <= d;
    host_oe <= !rd;
    repeat (2) @(posedge clk);
    if (!sep) begin
      parallel_data_strobe_n <= 1'b0;
    end else if (rd) begin
      read_strobe_n <= 1'b0;
    end else begin
      write_strobe_n <= 1'b0;
    end
    repeat (8) @(posedge clk);
    q = bus;
    parallel_data_strobe_n <= 1'b1;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    repeat (8) @(posedge clk);
    chip_sel_n <= 1'b1;
    host_oe <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  // One 16-bit serial frame; read bits taken on the edge opposite launch
  task ser(input logic es, input logic rd, input logic [5:0] a,
           input logic [7:0] d, output logic [7:0] q);
    logic [15:0] f;
    f = {d, 1'b0, a, rd};
    q = 8'h00;
    @(posedge clk);
    output_edge_select <= es;
    chip_sel_n <= 1'b0;
    repeat (4) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      serial_in <= f[i];
      repeat (4) @(posedge clk);
      if (i >= 8 && es) q[i-8] = serial_out;
      shift_clk <= 1'b1;
      repeat (4) @(posedge clk);
      if (i >= 8 && !es) q[i-8] = serial_out;
      shift_clk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    chip_sel_n <= 1'b1;
    serial_in <= ~f[15];
    repeat (8) @(posedge clk);
  endtask
endmodule

// ===== tb/control_port_pin_functions_bench.sv
// Purpose: Self-checking bench for the control port block
// Assumes: Host model drives all port pins, bench drives straps
// Notes: Data bus idles low through its pull-down when nobody drives
`timescale 1ns/1ps
module control_port_pin_functions_bench;
  logic clk, reset, clk_en;
  logic [1:0] if_mode, ch1_pattern_select, ch2_loopback_select;
  logic chip_sel_n, shift_clk, output_edge_select, serial_in, serial_out;
  logic [5:0] addr;
  logic parallel_data_strobe_n, read_not_write, read_strobe_n;
  logic write_strobe_n, host_oe, data_oe;
  logic [7:0] host_data, data_out, bus, q;
  logic [1:0] ch1_tx_pattern_r, ch2_loopback_r;
  logic ch2_inband_loop_r;
  int fails = 0;
  int cmp_count = 0;

  // Two-way data bus resolution
  assign bus = data_oe ? data_out : (host_oe ? host_data : 8'h00);

  cpp_port cpp_port_i (.clk(clk), .reset(reset), .clk_en(clk_en),
    .if_mode(if_mode), .chip_sel_n(chip_sel_n), .shift_clk(shift_clk),
    .output_edge_select(output_edge_select), .serial_in(serial_in),
    .serial_out(serial_out), .addr(addr),
    .parallel_data_strobe_n(parallel_data_strobe_n),
    .read_not_write(read_not_write), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .data_in(bus), .data_out(data_out),
    .data_oe(data_oe), .ch1_pattern_select(ch1_pattern_select),
    .ch2_loopback_select(ch2_loopback_select),
    .ch1_tx_pattern_r(ch1_tx_pattern_r), .ch2_loopback_r(ch2_loopback_r),
    .ch2_inband_loop_r(ch2_inband_loop_r));

  cpp_host_model cpp_host_model_i (.clk(clk), .chip_sel_n(chip_sel_n),
    .shift_clk(shift_clk), .output_edge_select(output_edge_select),
    .serial_in(serial_in), .serial_out(serial_out), .addr(addr),
    .parallel_data_strobe_n(parallel_data_strobe_n),
    .read_not_write(read_not_write), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .host_data(host_data),
    .host_oe(host_oe), .bus(bus));

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Four pin code pairs, each code once per pin, then a low clock enable must freeze outputs
  task t_hw;
    if_mode <= cpp_pkg::MODE_HW;
    for (int i = 0; i < 4; i++) begin
      ch1_pattern_select <= 2'(i);
      ch2_loopback_select <= 2'(3 - i);
      repeat (6) @(posedge clk);
      chk(ch1_tx_pattern_r, 8'(i));
      chk(ch2_loopback_r, 8'(3 - i));
      chk(ch2_inband_loop_r, 8'h00);
    end
    clk_en <= 1'b0;
    ch1_pattern_select <= 2'h1;
    repeat (6) @(posedge clk);
    chk(ch1_tx_pattern_r, 8'h03);
    clk_en <= 1'b1;
    repeat (6) @(posedge clk);
    chk(ch1_tx_pattern_r, 8'h01);
    $display("t_hw done");
  endtask

  // Separate strobes; a deselected write must leave the location alone
  task t_sep;
    if_mode <= cpp_pkg::MODE_SEP_STROBE;
    cpp_host_model_i.par(1, 0, 1, 6'h05, 8'hA5, q);
    cpp_host_model_i.par(1, 1, 1, 6'h05, 8'h00, q);
    chk(q, 8'hA5);
    cpp_host_model_i.par(1, 0, 0, 6'h05, 8'h3C, q);
    cpp_host_model_i.par(1, 1, 1, 6'h05, 8'h00, q);
    chk(q, 8'hA5);
    chk(data_oe, 8'h00);
    $display("t_sep done");
  endtask

  // Strobe plus direction, top and bottom addresses
  task t_dir;
    if_mode <= cpp_pkg::MODE_STROBE_DIR;
    cpp_host_model_i.par(0, 0, 1, 6'h3F, 8'h5A, q);
    cpp_host_model_i.par(0, 0, 1, 6'h00, 8'hFF, q);
    cpp_host_model_i.par(0, 1, 1, 6'h3F, 8'h00, q);
    chk(q, 8'h5A);
    cpp_host_model_i.par(0, 1, 1, 6'h00, 8'h00, q);
    chk(q, 8'hFF);
    $display("t_dir done");
  endtask

  // Serial write, read back with both launch edges, then loop control
  task t_ser;
    if_mode <= cpp_pkg::MODE_SERIAL;
    cpp_host_model_i.ser(0, 0, 6'h2A, 8'hC3, q);
    cpp_host_model_i.ser(0, 1, 6'h2A, 8'h00, q);
    chk(q, 8'hC3);
    cpp_host_model_i.ser(1, 1, 6'h2A, 8'h00, q);
    chk(q, 8'hC3);
    cpp_host_model_i.ser(0, 0, cpp_pkg::LOOP_REG_ADDR, 8'h07, q);
    chk(ch2_inband_loop_r, 8'h01);
    chk(ch2_loopback_r, 8'h03);
    ch2_loopback_select <= 2'h0;
    if_mode <= cpp_pkg::MODE_HW;
    repeat (6) @(posedge clk);
    chk(ch2_inband_loop_r, 8'h00);
    $display("t_ser done");
  endtask

  // Watchdog, well past the expected run of about 840 clocks
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up();
  end

  // Reset, then the tests
  initial begin
    reset = 1'b1;
    clk_en = 1'b1;
    if_mode = cpp_pkg::MODE_HW;
    ch1_pattern_select = 2'h0;
    ch2_loopback_select = 2'h0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    t_hw();
    t_sep();
    t_dir();
    t_ser();
    wrap_up();
  end
endmodule
